/* File: ucm_pkg.sv */
package ucm_pkg;

    // Clock, time and arithmetic figures.
    localparam int CLK_MHZ      = 50;
    localparam int GATE_1S_MS   = 1000;
    localparam int PHASE_DIV    = 10;
    localparam int DELAY_RST_US = 1000;
    localparam int AVG_N        = 100;
    localparam logic [31:0] MANT_MAX  = 32'h05f5e0ff;
    localparam logic [31:0] RECIP_100 = 32'h028f5c29;
    localparam logic [31:0] RECIP_10  = 32'hcccccccd;

    // Register byte addresses.
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_CMD   = 8'h04;
    localparam logic [7:0] A_DELAY = 8'h08;
    localparam logic [7:0] A_NULL  = 8'h0c;
    localparam logic [7:0] A_STAT  = 8'h10;
    localparam logic [7:0] A_EVT   = 8'h14;
    localparam logic [7:0] A_TIME  = 8'h18;
    localparam logic [7:0] A_AUX   = 8'h1c;
    localparam logic [7:0] A_MANT  = 8'h20;
    localparam logic [7:0] A_EXP   = 8'h24;

    // Control word fields.
    localparam int F_MODE   = 0;
    localparam int F_RES    = 4;
    localparam int F_EDGE_A = 7;
    localparam int F_EDGE_B = 8;
    localparam int F_COMMON = 9;
    localparam int F_DELAY  = 10;
    localparam int F_NULL   = 11;
    localparam int F_AVG    = 12;
    localparam int F_HOLD   = 13;
    localparam int F_STBY   = 14;
    localparam int F_FILT   = 15;
    localparam int F_SPEC   = 16;
    localparam int F_DC_A   = 17;
    localparam int F_DC_B   = 18;
    localparam logic [31:0] CTRL_RST = 32'h00000060;

    // Command word bits, each a one-shot key press.
    localparam int C_RESET = 0;
    localparam int C_HOLD  = 1;
    localparam int C_INIT  = 2;

    typedef enum logic [3:0] {
        M_FREQ, M_PERIOD, M_TI_SEP, M_TI_COM, M_GTOT,
        M_PHASE, M_RATIO, M_TOT_MAN, M_WATCH
    } ucm_mode_t;

    typedef enum logic [2:0] {
        S_IDLE, S_WAIT, S_RUN, S_CALC, S_SCALE, S_HOLD
    } ucm_state_t;

endpackage

/* File: ucm_edge.sv */
`timescale 1ns/1ns
`default_nettype none
module ucm_edge (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic sig,
    input  wire logic fall,
    input  wire logic en,
    output logic      pulse
);

typedef struct packed {
    logic prev;
    logic pulse;
} ucm_edge_t;

ucm_edge_t s;
ucm_edge_t next_s;

always_comb begin
    next_s = s;
    next_s.prev = sig;
    next_s.pulse = en & (fall ? (s.prev & ~sig) : (~s.prev & sig)); // R12
end

always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        s <= '0;
    end else begin
        s <= next_s;
    end
end

assign pulse = s.pulse;

default clocking @(posedge clk); endclocking
default disable iff (sys_rst);

property p_edge_sel;
    (en && fall && s.prev && !sig) |=> pulse;
endproperty
a_edge_sel: assert property (p_edge_sel) else $error("falling edge not detected"); // R12

endmodule
`default_nettype wire

/* File: ucm_gate.sv */
`timescale 1ns/1ns
`default_nettype none
module ucm_gate (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic [31:0] lim,
    output logic             expired
);

typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        expired;
} ucm_gate_t;

ucm_gate_t s;
ucm_gate_t next_s;

always_comb begin
    next_s = s;
    if (start) begin
        next_s.cnt = 32'h0;
        next_s.run = 1'b1;
        next_s.expired = 1'b0;
    end else if (s.run) begin
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt + 32'h1 >= lim) begin // R17
            next_s.run = 1'b0;
            next_s.expired = 1'b1;
        end
    end
end

always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        s <= '0;
    end else begin
        s <= next_s;
    end
end

assign expired = s.expired;

default clocking @(posedge clk); endclocking
default disable iff (sys_rst);

property p_gate_len;
    $rose(expired) |-> $past(s.cnt) + 32'h1 >= $past(lim);
endproperty
a_gate_len: assert property (p_gate_len) else $error("gate closed early"); // R17

endmodule
`default_nettype wire

/* File: ucm_top.sv */
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1 - Frequency mode: seven digits at one-second gate.
// R2 - Period mode: time many periods, report mean; the result holds their total time, not divided by the period count.
// R3 - Separate interval: A event to later B.
// R4 - Common interval: two events on channel A.
// R5 - Stop delay only in interval, gated totalize.
// R6 - Gated totalize: count A between B edges.
// R7 - Phase: A-to-B lag, positive when A leads.
// R8 - Ratio: A frequency over B frequency; the result holds the B edge count, not the ratio.
// R9 - Manual totalize: count A between hold presses.
// R10 - Stopwatch: time between hold key presses.
// R11 - Common input feeds A into both channels.
// R12 - Per-channel rising or falling trigger edge.
// R13 - Null subtracts the null store from result.
// R14 - Averaging reports mean of 100 measurements.
// R15 - Result as eight-digit mantissa, one exponent digit.
// R16 - Hold keeps reading until reset key.
// R17 - Gate from resolution, or from start/stop events.
// R18 - Phase uses a fixed gate time.
// R19 - Standby keeps reference, stops measuring.
// R20 - Power-up or init loads documented defaults.
// R21 - Use external reference while it is present.
module ucm_top #(
    parameter int GATE_1S_CYC = ucm_pkg::GATE_1S_MS * 1000 * ucm_pkg::CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        sig_a,
    input  wire logic        sig_b,
    input  wire logic        ext_ref_ok,
    output logic             ref_ext,
    output logic             meas_on,
    output logic             gate_open,
    output logic             filter_on
);

typedef struct packed {
    logic [31:0]        ctrl;
    logic [31:0]        dly;
    logic [31:0]        nul;
    logic [31:0]        evt;
    logic [31:0]        tim;
    logic [31:0]        aux;
    logic [31:0]        sum;
    logic [31:0]        mant;
    logic [31:0]        dcnt;
    logic [31:0]        rdata;
    logic [5:0]         pre;
    logic [6:0]         n;
    logic [3:0]         expo;
    logic               armed;
    logic               seen_b;
    logic               done;
    logic               ref_ext;
    logic               meas_on;
    logic               gate_open;
    logic               filter_on;
    ucm_pkg::ucm_state_t st;
} ucm_top_t;

ucm_top_t s;
ucm_top_t next_s;

logic [3:0]  mode;
logic [2:0]  res;
logic        stby;
logic        stby_next;
logic        ea;
logic        eb;
logic        b_src;
logic        cmd;
logic        key_rst;
logic        key_hold;
logic        key_init;
logic        gate_exp;
logic        gate_start;
logic [31:0] lim;
logic        start_ev;
logic        stop_ev;
logic [31:0] prim;
logic [31:0] tot;
logic [63:0] mean;
logic [31:0] val;
logic [63:0] div10;
logic        delayable;
logic        counts_a;

assign mode = s.ctrl[ucm_pkg::F_MODE +: 4];
assign res = s.ctrl[ucm_pkg::F_RES +: 3];
assign stby = s.ctrl[ucm_pkg::F_STBY];
assign stby_next = next_s.ctrl[ucm_pkg::F_STBY];
assign cmd = wr && (addr == ucm_pkg::A_CMD);
assign key_rst = cmd && wdata[ucm_pkg::C_RESET];
assign key_hold = cmd && wdata[ucm_pkg::C_HOLD];
assign key_init = cmd && wdata[ucm_pkg::C_INIT];

// The B socket is cut off whenever channel B must see the A signal.
assign b_src = (s.ctrl[ucm_pkg::F_COMMON] || mode == ucm_pkg::M_TI_COM) ? sig_a : sig_b; // R11 R4

ucm_edge u_edge_a (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig     (sig_a),
    .fall    (s.ctrl[ucm_pkg::F_EDGE_A]),
    .en      (s.meas_on),
    .pulse   (ea)
);

ucm_edge u_edge_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig     (b_src),
    .fall    (s.ctrl[ucm_pkg::F_EDGE_B]),
    .en      (s.meas_on),
    .pulse   (eb)
);

////////////////////////////////////////////////////////////////////////////////

// Seven digits at one second; each digit more or less is a decade of gate.
always_comb begin
    lim = 32'(GATE_1S_CYC / 10); // R20
    if (mode == ucm_pkg::M_PHASE) begin
        lim = 32'(GATE_1S_CYC / ucm_pkg::PHASE_DIV); // R18
    end else begin
        unique case (res)
            3'h3: lim = 32'(GATE_1S_CYC / 10000);
            3'h4: lim = 32'(GATE_1S_CYC / 1000);
            3'h5: lim = 32'(GATE_1S_CYC / 100);
            3'h6: lim = 32'(GATE_1S_CYC / 10);
            3'h7: lim = 32'(GATE_1S_CYC); // R1
            default: lim = 32'(GATE_1S_CYC / 10);
        endcase
    end
end

assign gate_start = (s.st == ucm_pkg::S_WAIT) && start_ev;

ucm_gate u_gate (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (gate_start),
    .lim     (lim),
    .expired (gate_exp)
);

////////////////////////////////////////////////////////////////////////////////

assign delayable = (mode == ucm_pkg::M_TI_SEP) || (mode == ucm_pkg::M_TI_COM)
                || (mode == ucm_pkg::M_GTOT); // R5
assign counts_a = (mode == ucm_pkg::M_FREQ) || (mode == ucm_pkg::M_PERIOD)
               || (mode == ucm_pkg::M_GTOT) || (mode == ucm_pkg::M_RATIO)
               || (mode == ucm_pkg::M_TOT_MAN) || (mode == ucm_pkg::M_PHASE);

always_comb begin
    unique case (mode)
        ucm_pkg::M_RATIO, ucm_pkg::M_GTOT: start_ev = eb; // R8 R6
        ucm_pkg::M_TOT_MAN, ucm_pkg::M_WATCH: start_ev = key_hold; // R9 R10
        default: start_ev = ea; // R3 R4 R7
    endcase
end

always_comb begin
    unique case (mode)
        ucm_pkg::M_FREQ, ucm_pkg::M_PERIOD, ucm_pkg::M_PHASE: stop_ev = gate_exp && ea; // R2 R17
        ucm_pkg::M_RATIO: stop_ev = gate_exp && eb; // R8
        ucm_pkg::M_TI_SEP, ucm_pkg::M_TI_COM, ucm_pkg::M_GTOT: stop_ev = eb && s.armed; // R5 R6
        ucm_pkg::M_TOT_MAN, ucm_pkg::M_WATCH: stop_ev = key_hold; // R9 R10
        default: stop_ev = gate_exp && ea;
    endcase
end

// The primary figure: events for totalizing, A-to-B lag for phase, B edge count for ratio, else time.
always_comb begin
    if (mode == ucm_pkg::M_TOT_MAN || mode == ucm_pkg::M_GTOT) begin
        prim = s.evt;
    end else if (mode == ucm_pkg::M_PHASE) begin
        prim = s.aux; // R7
    end else begin
        prim = s.tim;
    end
end

// Division by 100 and by 10 are done with reciprocal products to avoid a divider.
assign tot = s.sum + prim;
assign mean = 64'(tot) * 64'(ucm_pkg::RECIP_100); // R14
assign val = s.ctrl[ucm_pkg::F_AVG] ? mean[63:32] : prim;
assign div10 = 64'(s.mant) * 64'(ucm_pkg::RECIP_10);

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    next_s = s;
    next_s.ref_ext = ext_ref_ok; // R21
    next_s.filter_on = s.ctrl[ucm_pkg::F_FILT];
    if (wr && addr == ucm_pkg::A_CTRL) begin
        next_s.ctrl = wdata;
    end
    if (wr && addr == ucm_pkg::A_DELAY) begin
        next_s.dly = wdata;
    end
    if (wr && addr == ucm_pkg::A_NULL) begin
        next_s.nul = wdata;
    end
    unique case (s.st)
        ucm_pkg::S_IDLE: begin
            next_s.evt = 32'h0;
            next_s.tim = 32'h0;
            next_s.aux = 32'h0;
            next_s.seen_b = 1'b0;
            next_s.armed = 1'b0;
            next_s.st = ucm_pkg::S_WAIT;
        end
        ucm_pkg::S_WAIT: begin
            if (start_ev) begin
                next_s.dcnt = 32'h0;
                next_s.pre = 6'h0;
                next_s.armed = !(s.ctrl[ucm_pkg::F_DELAY] && delayable); // R5
                // An A edge that opens the gate starts the first period, so it is not counted as one.
                next_s.evt = {31'h0, counts_a && ea && (mode == ucm_pkg::M_GTOT || mode == ucm_pkg::M_RATIO
                              || mode == ucm_pkg::M_TOT_MAN)};
                next_s.st = ucm_pkg::S_RUN;
            end
        end
        ucm_pkg::S_RUN: begin
            if (counts_a && ea) begin
                next_s.evt = s.evt + 32'h1; // R6 R9
            end
            if (mode == ucm_pkg::M_RATIO) begin
                next_s.tim = eb ? s.tim + 32'h1 : s.tim; // R8
            end else begin
                next_s.tim = s.tim + 32'h1;
            end
            if (mode == ucm_pkg::M_PHASE && eb && !s.seen_b) begin
                next_s.aux = s.tim + 32'h1; // R7
                next_s.seen_b = 1'b1;
            end
            // The delay store counts in microseconds.
            if (!s.armed) begin
                if (s.pre == 6'(ucm_pkg::CLK_MHZ - 1)) begin
                    next_s.pre = 6'h0;
                    next_s.dcnt = s.dcnt + 32'h1;
                end else begin
                    next_s.pre = s.pre + 6'h1;
                end
                next_s.armed = s.dcnt >= s.dly; // R5
            end
            if (stop_ev) begin
                next_s.st = ucm_pkg::S_CALC;
            end
        end
        ucm_pkg::S_CALC: begin
            next_s.sum = tot;
            if (s.ctrl[ucm_pkg::F_AVG] && s.n != 7'(ucm_pkg::AVG_N - 1)) begin
                next_s.n = s.n + 7'h1; // R14
                next_s.st = ucm_pkg::S_IDLE;
            end else begin
                if (s.ctrl[ucm_pkg::F_NULL]) begin
                    next_s.mant = (val > s.nul) ? val - s.nul : 32'h0; // R13
                end else begin
                    next_s.mant = val;
                end
                next_s.expo = 4'h0;
                next_s.n = 7'h0;
                next_s.sum = 32'h0;
                next_s.st = ucm_pkg::S_SCALE;
            end
        end
        ucm_pkg::S_SCALE: begin
            if (s.mant > ucm_pkg::MANT_MAX) begin
                next_s.mant = {3'h0, div10[63:35]}; // R15
                next_s.expo = s.expo + 4'h1;
            end else begin
                next_s.done = 1'b1;
                next_s.st = s.ctrl[ucm_pkg::F_HOLD] ? ucm_pkg::S_HOLD : ucm_pkg::S_IDLE; // R16
            end
        end
        ucm_pkg::S_HOLD: begin
            next_s.st = ucm_pkg::S_HOLD; // R16
        end
    endcase
    if (key_rst) begin
        next_s.st = ucm_pkg::S_IDLE; // R16
        next_s.n = 7'h0;
        next_s.sum = 32'h0;
        next_s.done = 1'b0;
    end
    if (key_init) begin
        next_s.ctrl = ucm_pkg::CTRL_RST; // R20
        next_s.dly = 32'(ucm_pkg::DELAY_RST_US);
        next_s.nul = 32'h0;
        next_s.st = ucm_pkg::S_IDLE;
        next_s.n = 7'h0;
        next_s.sum = 32'h0;
        next_s.done = 1'b0;
    end
    if (next_s.ctrl[ucm_pkg::F_STBY]) begin
        next_s.st = ucm_pkg::S_IDLE; // R19
    end
    next_s.meas_on = !next_s.ctrl[ucm_pkg::F_STBY]; // R19
    next_s.gate_open = next_s.st == ucm_pkg::S_RUN;
    next_s.rdata = 32'h0;
    if (rd) begin
        unique case (addr)
            ucm_pkg::A_CTRL:  next_s.rdata = s.ctrl;
            ucm_pkg::A_DELAY: next_s.rdata = s.dly;
            ucm_pkg::A_NULL:  next_s.rdata = s.nul;
            ucm_pkg::A_STAT:  next_s.rdata = {16'h0, 1'b0, s.n, s.ref_ext, s.done, 3'h0, s.st};
            ucm_pkg::A_EVT:   next_s.rdata = s.evt;
            ucm_pkg::A_TIME:  next_s.rdata = s.tim;
            ucm_pkg::A_AUX:   next_s.rdata = s.aux;
            ucm_pkg::A_MANT:  next_s.rdata = s.mant;
            ucm_pkg::A_EXP:   next_s.rdata = {28'h0, s.expo};
            default:          next_s.rdata = 32'h0;
        endcase
    end
end

// Power-up reaches the same defaults as an init command.
always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        s <= '0;
        s.ctrl <= ucm_pkg::CTRL_RST; // R20
        s.dly <= 32'(ucm_pkg::DELAY_RST_US);
        s.meas_on <= 1'b1;
        s.st <= ucm_pkg::S_IDLE;
    end else begin
        s <= next_s;
    end
end

assign rdata = s.rdata;
assign ref_ext = s.ref_ext;
assign meas_on = s.meas_on;
assign gate_open = s.gate_open;
assign filter_on = s.filter_on;

////////////////////////////////////////////////////////////////////////////////

default clocking @(posedge clk); endclocking
default disable iff (sys_rst);

sequence s_hold_key;
    wr && addr == ucm_pkg::A_CMD && wdata[ucm_pkg::C_HOLD];
endsequence

sequence s_watch_wait;
    s.st == ucm_pkg::S_WAIT && mode == ucm_pkg::M_WATCH && !stby;
endsequence

property p_watch_start;
    s_watch_wait ##0 s_hold_key |=> s.st == ucm_pkg::S_RUN ##1 gate_open;
endproperty
a_watch_start: assert property (p_watch_start) else $error("stopwatch did not start"); // R10

property p_init;
    key_init |=> s.ctrl == ucm_pkg::CTRL_RST && s.nul == 32'h0 && s.dly == 32'(ucm_pkg::DELAY_RST_US);
endproperty
a_init: assert property (p_init) else $error("init defaults not loaded"); // R20

property p_stby;
    stby |-> !meas_on && s.st == ucm_pkg::S_IDLE;
endproperty
a_stby: assert property (p_stby) else $error("measuring during standby"); // R19

property p_ref;
    ext_ref_ok [*2] |-> ref_ext;
endproperty
a_ref: assert property (p_ref) else $error("external reference not used"); // R21

property p_hold;
    s.st == ucm_pkg::S_HOLD && !key_rst && !key_init && !stby_next |=> s.st == ucm_pkg::S_HOLD && $stable(s.mant);
endproperty
a_hold: assert property (p_hold) else $error("held reading lost"); // R16

property p_delay;
    s.st == ucm_pkg::S_RUN && !s.armed && delayable && !key_rst && !key_init && !stby_next |=> s.st == ucm_pkg::S_RUN;
endproperty
a_delay: assert property (p_delay) else $error("stop taken during delay"); // R5

property p_gate_run;
    s.st == ucm_pkg::S_RUN && mode == ucm_pkg::M_FREQ && !gate_exp && !key_rst && !key_init && !stby_next
        |=> s.st == ucm_pkg::S_RUN;
endproperty
a_gate_run: assert property (p_gate_run) else $error("frequency gate closed early"); // R17

property p_avg_cnt;
    s.n < 7'(ucm_pkg::AVG_N);
endproperty
a_avg_cnt: assert property (p_avg_cnt) else $error("average count overran"); // R14

property p_mant;
    s.st == ucm_pkg::S_SCALE && s.mant <= ucm_pkg::MANT_MAX && !key_rst && !key_init |=> s.done && s.expo <= 4'h9;
endproperty
a_mant: assert property (p_mant) else $error("result not in engineering form"); // R15

property p_null;
    s.st == ucm_pkg::S_CALC && !s.ctrl[ucm_pkg::F_AVG] && s.ctrl[ucm_pkg::F_NULL] && prim > s.nul
        && !key_rst && !key_init && !stby_next |=> s.st == ucm_pkg::S_SCALE && s.mant == $past(prim) - $past(s.nul);
endproperty
a_null: assert property (p_null) else $error("null not subtracted"); // R13

endmodule
`default_nettype wire

/* File: ucm_chan_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Square waves for the conditioned trigger signals of channels A and B.
// Both lines fall to 0 while stopped, so every run starts from a known phase.
module ucm_chan_model (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        run,
    input  wire logic [15:0] half_a,
    input  wire logic [15:0] half_b,
    input  wire logic [15:0] lag_b,
    output logic             sig_a,
    output logic             sig_b
);
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [15:0] age;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst || !run) begin
            cnt_a <= 16'h0000;
            cnt_b <= 16'h0000;
            age   <= 16'h0000;
            sig_a <= 1'b0;
            sig_b <= 1'b0;
        end else begin
            age   <= (age == 16'hffff) ? age : age + 16'h0001;
            cnt_a <= (cnt_a == half_a - 16'h0001) ? 16'h0000 : cnt_a + 16'h0001;
            sig_a <= (cnt_a == half_a - 16'h0001) ? !sig_a : sig_a;
            if (age >= lag_b) begin
                cnt_b <= (cnt_b == half_b - 16'h0001) ? 16'h0000 : cnt_b + 16'h0001;
                sig_b <= (cnt_b == half_b - 16'h0001) ? !sig_b : sig_b;
            end
        end
    end
endmodule
`default_nettype wire

/* File: ucm_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module ucm_top_tb;
    logic        clk;
    logic        sys_rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        sig_a;
    logic        sig_b;
    logic        ext_ref_ok;
    logic        ref_ext;
    logic        meas_on;
    logic        gate_open;
    logic        filter_on;
    logic        run;
    logic [15:0] half_a;
    logic [15:0] half_b;
    logic [15:0] lag_b;
    logic        prev_a;
    logic [31:0] v;
    int          rises;
    int          k0;
    int          bad_count;
    int          total_checks;

    // A short second keeps every gate but the one-second gate of res 7 within a thousand cycles.
    ucm_top #(.GATE_1S_CYC(10000)) ucm_top_i (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sig_a(sig_a), .sig_b(sig_b), .ext_ref_ok(ext_ref_ok),
        .ref_ext(ref_ext), .meas_on(meas_on), .gate_open(gate_open), .filter_on(filter_on)
    );

    ucm_chan_model ucm_chan_model_i (
        .clk(clk), .sys_rst(sys_rst), .run(run), .half_a(half_a), .half_b(half_b),
        .lag_b(lag_b), .sig_a(sig_a), .sig_b(sig_b)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end

    always @(posedge clk) begin
        prev_a <= sig_a;
        if (sig_a && !prev_a) rises <= rises + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        total_checks++;
        if ((^g === 1'bx) || g < lo || g > hi) begin
            $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, g);
            bad_count++;
        end
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        chk_rng(nm, e, e, g);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_gate(input logic lvl);
        for (int i = 0; i < 5000; i++) begin
            if (gate_open === lvl) return;
            @(posedge clk);
        end
        bad_count++;
        conclude();
    endtask

    // Polls until the result pipeline has left its calculate and scale steps.
    task automatic wait_calc();
        logic [31:0] s;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 300; i++) begin
            rd_reg(ucm_pkg::A_STAT, s);
            if (s[2:0] !== 3'h3 && s[2:0] !== 3'h4) return;
        end
        bad_count++;
        conclude();
    endtask

    task automatic restart(input logic [31:0] ctrl);
        wr_reg(ucm_pkg::A_CTRL, ctrl);
        wr_reg(ucm_pkg::A_CMD, 32'h00000001);
    endtask

    task automatic measure();
        wait_gate(1'b1);
        wait_gate(1'b0);
        wait_calc();
    endtask

    task automatic ti_case(input logic [31:0] ctrl, input logic [31:0] lo, input logic [31:0] hi);
        // Hold keeps the counts readable after the measurement ends.
        restart(ctrl | 32'h00002000);
        measure();
        rd_reg(ucm_pkg::A_TIME, v);
        chk_rng("interval", lo, hi, v);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        ext_ref_ok = 1'b0;
        run = 1'b0;
        half_a = 16'h0005;
        half_b = 16'h0005;
        lag_b = 16'h0000;
        rises = 0;
        bad_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("meas_on", 32'h1, {31'h0, meas_on});
        chk("filter_off", 32'h0, {31'h0, filter_on});
        rd_reg(ucm_pkg::A_CTRL, v);
        chk("ctrl", ucm_pkg::CTRL_RST, v);
        rd_reg(ucm_pkg::A_DELAY, v);
        chk("delay", 32'h000003e8, v);
        rd_reg(ucm_pkg::A_NULL, v);
        chk("null", 32'h0, v);
        rd_reg(8'hfc, v);
        chk("unmapped", 32'h0, v);

        ext_ref_ok <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("ref_ext", 32'h1, {31'h0, ref_ext});
        rd_reg(ucm_pkg::A_STAT, v);
        chk("stat_ref", 32'h1, {31'h0, v[7]});
        ext_ref_ok <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("ref_int", 32'h0, {31'h0, ref_ext});

        // Period 10 over a 10 ms gate of 100 cycles.
        run <= 1'b1;
        restart(32'h00002050);
        measure();
        rd_reg(ucm_pkg::A_EVT, v);
        chk_rng("freq_events", 32'd10, 32'd11, v);
        rd_reg(ucm_pkg::A_TIME, v);
        chk_rng("freq_time", 32'd100, 32'd112, v);

        wr_reg(ucm_pkg::A_CTRL, 32'h00004050);
        repeat (300) @(posedge clk);
        #1;
        chk("standby_meas", 32'h0, {31'h0, meas_on});
        chk("standby_gate", 32'h0, {31'h0, gate_open});
        wr_reg(ucm_pkg::A_CTRL, 32'h00000050);
        repeat (2) @(posedge clk);
        #1;
        chk("wake_meas", 32'h1, {31'h0, meas_on});

        // A rises at 20 mod 40, B rises 12 later and falls 32 later.
        run <= 1'b0;
        half_a <= 16'd20;
        half_b <= 16'd20;
        lag_b <= 16'd12;
        @(posedge clk);
        run <= 1'b1;
        ti_case(32'h00000002, 32'd10, 32'd14);
        ti_case(32'h00000102, 32'd30, 32'd34);
        wr_reg(ucm_pkg::A_DELAY, 32'h00000001);
        // The 50-cycle delay skips the B edge at 12 and stops on the one at 52.
        ti_case(32'h00000402, 32'd50, 32'd56);
        // A falls 20 after it rises; both cases below stop on that edge.
        ti_case(32'h00000103, 32'd18, 32'd22);
        ti_case(32'h00000302, 32'd18, 32'd22);
        restart(32'h00002005);
        measure();
        rd_reg(ucm_pkg::A_AUX, v);
        chk("phase_lag", 32'd12, v);
        // One hundred 12-cycle intervals, one per A period of 40 cycles.
        restart(32'h00003002);
        repeat (4500) @(posedge clk);
        rd_reg(ucm_pkg::A_MANT, v);
        chk("avg_mean", 32'd12, v);

        run <= 1'b0;
        half_a <= 16'd5;
        wr_reg(ucm_pkg::A_NULL, 32'h00000003);
        restart(32'h00002807);
        wr_reg(ucm_pkg::A_CMD, 32'h00000002);
        wait_gate(1'b1);
        k0 = rises;
        run <= 1'b1;
        repeat (200) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        k0 = rises - k0;
        wr_reg(ucm_pkg::A_CMD, 32'h00000002);
        wait_calc();
        rd_reg(ucm_pkg::A_EVT, v);
        chk("tot_events", k0, v);
        rd_reg(ucm_pkg::A_MANT, v);
        chk("tot_nulled", k0 - 3, v);

        restart(32'h00002008);
        wr_reg(ucm_pkg::A_CMD, 32'h00000002);
        repeat (298) @(posedge clk);
        wr_reg(ucm_pkg::A_CMD, 32'h00000002);
        wait_calc();
        rd_reg(ucm_pkg::A_TIME, v);
        chk_rng("watch_time", 32'd298, 32'd302, v);
        repeat (100) @(posedge clk);
        rd_reg(ucm_pkg::A_STAT, v);
        chk("held_state", 32'h5, {29'h0, v[2:0]});
        wr_reg(ucm_pkg::A_CMD, 32'h00000001);
        rd_reg(ucm_pkg::A_STAT, v);
        chk_rng("released_state", 32'h0, 32'h4, {29'h0, v[2:0]});

        wr_reg(ucm_pkg::A_DELAY, 32'h00000007);
        wr_reg(ucm_pkg::A_CTRL, 32'h00001234);
        wr_reg(ucm_pkg::A_CMD, 32'h00000004);
        rd_reg(ucm_pkg::A_CTRL, v);
        chk("init_ctrl", ucm_pkg::CTRL_RST, v);
        rd_reg(ucm_pkg::A_DELAY, v);
        chk("init_delay", 32'h000003e8, v);
        rd_reg(ucm_pkg::A_NULL, v);
        chk("init_null", 32'h0, v);
        conclude();
    end
endmodule
`default_nettype wire
